//--- addon_gcs_pkg.sv
package addon_gcs_pkg;

   // Register placement
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] GCS_OFFSET = 8'h3C;

   // Field positions
   localparam int GO_BIT = 31;
   localparam int OP_HI_BIT = 30;
   localparam int OP_LO_BIT = 29;
   localparam int XFER_EN_BIT = 28;
   localparam int MBOX_RST_BIT = 27;
   localparam int OUT_RST_BIT = 26;
   localparam int IN_RST_BIT = 25;
   localparam int PORT_LSB = 16;
   localparam int BIST_LSB = 12;
   localparam int WRZERO_BIT = 7;

   // Reset values
   localparam logic XFER_EN_RESET = 1'h0;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [15:0] NV_ADDR_RESET = 16'h0000;

   // Access step codes carried by the two op bits
   typedef enum logic [1:0] {
      NV_LOAD_LO = 2'h0,
      NV_LOAD_HI = 2'h1,
      NV_WRITE = 2'h2,
      NV_READ = 2'h3
   } nv_op_t;

   // Sequencer states, Gray along idle-access-capture-recover
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_ACCESS = 2'h1,
      SEQ_CAPTURE = 2'h3,
      SEQ_RECOVER = 2'h2
   } seq_state_t;

   // Timing of the external memory
   localparam int CLK_PERIOD_NS = 20;
   localparam int NV_WRITE_PULSE_NS = 100;
   localparam int NV_READ_ACCESS_NS = 150;
   localparam int NV_RECOVER_NS = 40;
   localparam int NV_WRITE_CYCLES =
      (NV_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_READ_CYCLES =
      (NV_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NV_RECOVER_CYCLES =
      (NV_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_SETTLE_CYCLES = 2;

endpackage : addon_gcs_pkg

//--- addon_general_ctrl_status.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module addon_general_ctrl_status #(
   parameter int WRITE_CYCLES = addon_gcs_pkg::NV_WRITE_CYCLES,
   parameter int READ_CYCLES = addon_gcs_pkg::NV_READ_CYCLES,
   parameter int RECOVER_CYCLES = addon_gcs_pkg::NV_RECOVER_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic [addon_gcs_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // Controls to the rest of the add-on side
   output logic xferCountEnable,
   output logic mailboxFlagReset,
   output logic outFifoStatusReset,
   output logic inFifoStatusReset,
   // Status from the rest of the add-on side
   input wire logic [3:0] bistCode,
   input wire logic writeCountZero,
   input wire logic addonMasterEnable,
   // External non-volatile memory
   output logic [15:0] nvAddr,
   output logic [7:0] nvDataOut,
   output logic nvDataOe,
   output logic nvWriteN,
   output logic nvReadN,
   input wire logic [7:0] nvDataIn
);
   import addon_gcs_pkg::*;

   function automatic logic isHit(input logic [ADDR_W-1:0] a);
      isHit = (a == GCS_OFFSET);
   endfunction : isHit

   logic wrHit, rdHit, stepStart;
   logic nvBusy;
   logic [7:0] nvReadByte;
   nv_op_t stepOp;
   logic next_xferEn, next_mboxRst, next_outRst, next_inRst;
   logic [31:0] next_rdata;

   assign wrHit = regWrite && isHit(regAddr);
   assign rdHit = regRead && isHit(regAddr);
   assign stepOp = nv_op_t'(regWdata[OP_HI_BIT:OP_LO_BIT]);
   // go bit launches a step
   // Steps written while busy are dropped, not queued
   assign stepStart = wrHit && regWdata[GO_BIT] && !nvBusy;

   // steps run in order by the sequencer
   nv_access_seq #(
      .WRITE_CYCLES(WRITE_CYCLES),
      .READ_CYCLES(READ_CYCLES),
      .RECOVER_CYCLES(RECOVER_CYCLES)
   ) u_seq (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .start(stepStart),
      .stepOp(stepOp),
      .stepByte(regWdata[PORT_LSB+7:PORT_LSB]),
      .busy(nvBusy),
      .readByte(nvReadByte),
      .nvAddr(nvAddr),
      .nvDataOut(nvDataOut),
      .nvDataOe(nvDataOe),
      .nvWriteN(nvWriteN),
      .nvReadN(nvReadN),
      .nvDataIn(nvDataIn)
   );

   always_comb begin
      next_xferEn = xferCountEnable;
      if (wrHit) begin
         next_xferEn = regWdata[XFER_EN_BIT];
      end
      next_mboxRst = wrHit && regWdata[MBOX_RST_BIT];
      next_outRst = wrHit && regWdata[OUT_RST_BIT];
      next_inRst = wrHit && regWdata[IN_RST_BIT];
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rdHit) begin
         next_rdata[GO_BIT] = nvBusy;
         next_rdata[XFER_EN_BIT] = xferCountEnable;
         next_rdata[PORT_LSB+7:PORT_LSB] = nvReadByte;
         next_rdata[BIST_LSB+3:BIST_LSB] = bistCode;
         next_rdata[WRZERO_BIT] = writeCountZero && addonMasterEnable;
         // reserved and pulse bits stay zero
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         xferCountEnable <= XFER_EN_RESET;
         mailboxFlagReset <= 1'b0;
         outFifoStatusReset <= 1'b0;
         inFifoStatusReset <= 1'b0;
         regRdata <= 32'h0000_0000;
      end else begin
         xferCountEnable <= next_xferEn;
         mailboxFlagReset <= next_mboxRst;
         outFifoStatusReset <= next_outRst;
         inFifoStatusReset <= next_inRst;
         regRdata <= next_rdata;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   a_xfer_enable_write: assert property (
      wrHit |=> xferCountEnable == $past(regWdata[XFER_EN_BIT]))
      else $error("count enable did not take written value");

   a_xfer_enable_hold: assert property (
      !wrHit |=> $stable(xferCountEnable))
      else $error("count enable changed without write");

   a_mbox_pulse_once: assert property (
      (wrHit && regWdata[MBOX_RST_BIT])
      ##1 !(wrHit && regWdata[MBOX_RST_BIT])
      |-> mailboxFlagReset ##1 !mailboxFlagReset)
      else $error("mailbox reset pulse wrong length");

   a_mbox_pulse_cause: assert property (
      mailboxFlagReset |-> $past(wrHit) && $past(regWdata[MBOX_RST_BIT]))
      else $error("mailbox reset pulse without write");

   a_out_status_pulse: assert property (
      outFifoStatusReset
      |-> $past(wrHit) && $past(regWdata[OUT_RST_BIT]))
      else $error("outbound reset pulse without write");

   a_out_status_fire: assert property (
      wrHit && regWdata[OUT_RST_BIT] |=> outFifoStatusReset)
      else $error("outbound reset pulse missing");

   a_in_status_pulse: assert property (
      wrHit && regWdata[IN_RST_BIT] |=> inFifoStatusReset)
      else $error("inbound reset pulse missing");

   a_in_status_cause: assert property (
      inFifoStatusReset |-> $past(wrHit) && $past(regWdata[IN_RST_BIT]))
      else $error("inbound reset pulse without write");

   a_port_low_load: assert property (
      stepStart && stepOp == NV_LOAD_LO
      |=> nvAddr[7:0] == $past(regWdata[PORT_LSB+7:PORT_LSB]) && !nvBusy)
      else $error("low address byte not loaded");

   a_port_high_load: assert property (
      stepStart && stepOp == NV_LOAD_HI
      |=> nvAddr[15:8] == $past(regWdata[PORT_LSB+7:PORT_LSB]))
      else $error("high address byte not loaded");

   a_write_strobe_len: assert property (
      stepStart && stepOp == NV_WRITE
      |=> (!nvWriteN && nvDataOe && nvBusy)[*5])
      else $error("write strobe shorter than pulse time");

   a_read_busy_span: assert property (
      stepStart && stepOp == NV_READ |=> (!nvReadN && nvBusy)[*8])
      else $error("read strobe shorter than access time");

   a_busy_ends: assert property (
      stepStart && regWdata[OP_HI_BIT] |-> ##[4:40] !nvBusy)
      else $error("access never returned ready");

   a_busy_ignores_go: assert property (
      nvBusy && wrHit |=> $stable(nvAddr))
      else $error("step accepted while busy");

   a_read_port_value: assert property (
      $fell(nvBusy) ##0 rdHit |=> regRdata[23:16] == $past(nvReadByte))
      else $error("port does not show fetched byte");

   a_bist_mirror_bits: assert property (
      rdHit |=> regRdata[BIST_LSB+3:BIST_LSB] == $past(bistCode))
      else $error("self-test field mismatch");

   a_count_zero_bit: assert property (
      rdHit |=> regRdata[WRZERO_BIT]
         == ($past(writeCountZero) && $past(addonMasterEnable)))
      else $error("count-zero bit wrong");

   a_reserved_read_zero: assert property (
      regRead |=> regRdata[27:24] == 4'h0 && regRdata[11:8] == 4'h0)
      else $error("reserved or pulse bits read nonzero");

   a_unmapped_read_zero: assert property (
      regRead && !isHit(regAddr) |=> regRdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_write_strobe_end: assert property (
      stepStart && stepOp == NV_WRITE |=> ##5 nvWriteN && nvDataOe)
      else $error("write strobe not released on time");

   a_write_oe_release: assert property (
      stepStart && stepOp == NV_WRITE
      |=> ##7 nvDataOe ##1 !nvDataOe)
      else $error("write data not released on time");

   a_write_busy_release: assert property (
      stepStart && stepOp == NV_WRITE |=> ##9 nvBusy ##1 !nvBusy)
      else $error("write step ready at wrong cycle");

   a_write_data_stable: assert property (
      nvDataOe |=> $stable(nvDataOut))
      else $error("write data moved while driven");

   a_strobe_needs_data: assert property (
      !nvWriteN |-> nvDataOe)
      else $error("write strobe without driven data");

   a_strobes_exclusive: assert property (
      nvWriteN || nvReadN)
      else $error("read and write strobes both active");

   a_read_no_drive: assert property (
      stepStart && stepOp == NV_READ
      |=> (!nvDataOe && nvWriteN)[*8])
      else $error("data driven during read step");

   a_read_strobe_end: assert property (
      stepStart && stepOp == NV_READ |=> ##10 !nvReadN)
      else $error("read strobe released before capture");

   a_read_done_ready: assert property (
      $rose(nvReadN) |-> nvBusy ##1 nvBusy ##1 !nvBusy)
      else $error("read step ready at wrong cycle");

   a_rdata_idle_zero: assert property (
      !rdHit |=> regRdata == 32'h0000_0000)
      else $error("read data not cleared after read");

   a_busy_bit_read: assert property (
      rdHit |=> regRdata[GO_BIT] == $past(nvBusy))
      else $error("ready bit does not show sequencer");

   a_enable_bit_read: assert property (
      rdHit |=> regRdata[XFER_EN_BIT] == $past(xferCountEnable))
      else $error("count enable bit reads wrong");

   a_op_bits_zero: assert property (
      regRead |=> regRdata[OP_HI_BIT:OP_LO_BIT] == 2'h0)
      else $error("op bits read nonzero");

   a_port_field_read: assert property (
      rdHit |=> regRdata[PORT_LSB+7:PORT_LSB] == $past(nvReadByte))
      else $error("port field does not show fetched byte");

   a_fetch_only_busy: assert property (
      !nvBusy |=> $stable(nvReadByte))
      else $error("fetched byte changed outside a step");

   a_go_low_no_step: assert property (
      wrHit && !regWdata[GO_BIT] && !nvBusy
      |=> !nvBusy && $stable(nvAddr))
      else $error("inactive write started a step");

   a_addr_step_quiet: assert property (
      stepStart && !regWdata[OP_HI_BIT]
      |=> !nvBusy && nvWriteN && nvReadN)
      else $error("address load touched the strobes");

   a_addr_hold_busy: assert property (
      nvBusy |=> $stable(nvAddr))
      else $error("address moved during a step");

   a_pulses_need_write: assert property (
      !wrHit |=> !mailboxFlagReset && !outFifoStatusReset
         && !inFifoStatusReset)
      else $error("reset pulse without register write");

   a_count_zero_gated: assert property (
      rdHit && !addonMasterEnable |=> !regRdata[WRZERO_BIT])
      else $error("count-zero bit shown while mastering off");

   c_write_step: cover property (
      stepStart && stepOp == NV_WRITE ##[1:20] $fell(nvBusy));
   c_read_step: cover property (
      stepStart && stepOp == NV_READ ##[1:30] $fell(nvBusy));
   c_mailbox_reset: cover property (mailboxFlagReset);
   c_both_fifo_resets: cover property (
      outFifoStatusReset && inFifoStatusReset);
   c_step_refused: cover property (
      nvBusy && wrHit && regWdata[GO_BIT]);

endmodule : addon_general_ctrl_status

//--- nv_access_seq.sv
`timescale 1ns/10ps
module nv_access_seq #(
   parameter int WRITE_CYCLES = addon_gcs_pkg::NV_WRITE_CYCLES,
   parameter int READ_CYCLES = addon_gcs_pkg::NV_READ_CYCLES,
   parameter int RECOVER_CYCLES = addon_gcs_pkg::NV_RECOVER_CYCLES,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Step request
   input wire logic start,
   input wire addon_gcs_pkg::nv_op_t stepOp,
   input wire logic [7:0] stepByte,
   output logic busy,
   output logic [7:0] readByte,
   // Memory pins
   output logic [15:0] nvAddr,
   output logic [7:0] nvDataOut,
   output logic nvDataOe,
   output logic nvWriteN,
   output logic nvReadN,
   input wire logic [7:0] nvDataIn
);
   import addon_gcs_pkg::*;

   generate
      if (WRITE_CYCLES < 1 || READ_CYCLES < 1 || RECOVER_CYCLES < 1 ||
          WRITE_CYCLES >= 2**CNT_W || READ_CYCLES >= 2**CNT_W ||
          RECOVER_CYCLES >= 2**CNT_W) begin : g_bad
         $error("nv_access_seq: cycle counts out of range");
      end
   endgenerate

   seq_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic readOp, next_readOp;
   logic next_busy, next_oe, next_writeN, next_readN;
   logic [7:0] next_readByte, next_dataOut;
   logic [15:0] next_addr;
   // Pin data synchroniser; stage one feeds only stage two
   logic [7:0] syncA, syncB, syncC;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_readOp = readOp;
      next_busy = busy;
      next_oe = nvDataOe;
      next_writeN = nvWriteN;
      next_readN = nvReadN;
      next_readByte = readByte;
      next_dataOut = nvDataOut;
      next_addr = nvAddr;
      case (state)
         SEQ_IDLE: begin
            if (start) begin
               case (stepOp)
                  NV_LOAD_LO: next_addr[7:0] = stepByte;
                  NV_LOAD_HI: next_addr[15:8] = stepByte;
                  NV_WRITE: begin
                     next_dataOut = stepByte;
                     next_oe = 1'b1;
                     next_writeN = 1'b0;
                     next_busy = 1'b1;
                     next_readOp = 1'b0;
                     next_cnt = CNT_W'(WRITE_CYCLES - 1);
                     next_state = SEQ_ACCESS;
                  end
                  default: begin
                     next_readN = 1'b0;
                     next_busy = 1'b1;
                     next_readOp = 1'b1;
                     next_cnt = CNT_W'(READ_CYCLES - 1);
                     next_state = SEQ_ACCESS;
                  end
               endcase
            end
         end
         // strobe held for the step's time
         SEQ_ACCESS: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else begin
               // Write data held three more cycles past the strobe
               next_writeN = 1'b1;
               next_cnt = CNT_W'(SYNC_SETTLE_CYCLES);
               next_state = SEQ_CAPTURE;
            end
         end
         SEQ_CAPTURE: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else if (!readOp || syncB == syncC) begin
               if (readOp) begin
                  next_readByte = syncC;
               end
               next_readN = 1'b1;
               next_oe = 1'b0;
               next_cnt = CNT_W'(RECOVER_CYCLES - 1);
               next_state = SEQ_RECOVER;
            end
         end
         SEQ_RECOVER: begin
            if (cnt != '0) begin
               next_cnt = cnt - 1'b1;
            end else begin
               next_busy = 1'b0;
               next_state = SEQ_IDLE;
            end
         end
         default: next_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= SEQ_IDLE;
         cnt <= '0;
         readOp <= 1'b0;
         busy <= 1'b0;
         nvDataOe <= 1'b0;
         nvWriteN <= 1'b1;
         nvReadN <= 1'b1;
         readByte <= PORT_RESET;
         nvDataOut <= PORT_RESET;
         nvAddr <= NV_ADDR_RESET;
         syncA <= 8'h00;
         syncB <= 8'h00;
         syncC <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         readOp <= next_readOp;
         busy <= next_busy;
         nvDataOe <= next_oe;
         nvWriteN <= next_writeN;
         nvReadN <= next_readN;
         readByte <= next_readByte;
         nvDataOut <= next_dataOut;
         nvAddr <= next_addr;
         syncA <= nvDataIn;
         syncB <= syncA;
         syncC <= syncB;
      end
   end

endmodule : nv_access_seq

//--- nv_mem_model.sv
`timescale 1ns/10ps
module nv_mem_model (
   // Memory pins
   input wire logic [15:0] nvAddr,
   input wire logic [7:0] nvDataOut,
   input wire logic nvDataOe,
   input wire logic nvWriteN,
   input wire logic nvReadN,
   output logic [7:0] nvDataIn,
   // Answer speed
   input wire logic slow
);
   logic [7:0] mem [logic [15:0]];
   initial nvDataIn = 8'hA5;
   always @(posedge nvWriteN) begin
      if (nvDataOe) begin
         mem[nvAddr] = nvDataOut;
      end
   end
   // Junk until the access time has passed
   always @(negedge nvReadN) begin
      nvDataIn = ~nvDataIn;
      // Off the clock edges so the pins never move as they are sampled
      #(slow ? 145 : 25);
      if (!nvReadN) begin
         nvDataIn = mem.exists(nvAddr) ? mem[nvAddr] : 8'hFF;
      end
   end
   // Released bus does not keep the last byte
   always @(posedge nvReadN) begin
      nvDataIn = ~nvDataIn;
   end
endmodule : nv_mem_model

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import addon_gcs_pkg::*;
   logic sys_clk, rstn, regWrite, regRead, slow;
   logic [ADDR_W-1:0] regAddr;
   logic [31:0] regWdata, regRdata, d;
   logic xferCountEnable, mailboxFlagReset, outFifoStatusReset;
   logic inFifoStatusReset, writeCountZero, addonMasterEnable;
   logic [3:0] bistCode;
   logic [15:0] nvAddr, a;
   logic [7:0] nvDataOut, nvDataIn, expPort, b;
   logic nvDataOe, nvWriteN, nvReadN, expEn;
   logic [7:0] expQ[$];
   int nErrors, checked;

   addon_general_ctrl_status i_addon_general_ctrl_status (
      .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .xferCountEnable(xferCountEnable),
      .mailboxFlagReset(mailboxFlagReset),
      .outFifoStatusReset(outFifoStatusReset),
      .inFifoStatusReset(inFifoStatusReset), .bistCode(bistCode),
      .writeCountZero(writeCountZero),
      .addonMasterEnable(addonMasterEnable), .nvAddr(nvAddr),
      .nvDataOut(nvDataOut), .nvDataOe(nvDataOe), .nvWriteN(nvWriteN),
      .nvReadN(nvReadN), .nvDataIn(nvDataIn));

   nv_mem_model i_nv_mem_model (
      .nvAddr(nvAddr), .nvDataOut(nvDataOut), .nvDataOe(nvDataOe),
      .nvWriteN(nvWriteN), .nvReadN(nvReadN), .nvDataIn(nvDataIn),
      .slow(slow));

   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      if (nErrors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] adr, input logic [31:0] w);
      @(posedge sys_clk);
      regWrite <= 1'h1;
      regAddr <= adr;
      regWdata <= w;
      @(posedge sys_clk);
      regWrite <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] r);
      @(posedge sys_clk);
      regRead <= 1'h1;
      regAddr <= adr;
      @(posedge sys_clk);
      regRead <= 1'h0;
      #1 r = regRdata;
   endtask : rd

   function automatic logic [31:0] expWord();
      return {3'h0, expEn, 4'h0, expPort, bistCode, 4'h0,
         writeCountZero & addonMasterEnable, 7'h00};
   endfunction : expWord

   task automatic step(input nv_op_t op, input logic [7:0] by);
      wr(GCS_OFFSET, {1'h1, op, expEn, 4'h0, by, 16'h0000});
   endtask : step

   // Bounded poll of the ready bit
   task automatic poll();
      int n;
      rd(GCS_OFFSET, d);
      cmp(d[31], 1'h1);
      n = 0;
      while (d[31] !== 1'h0 && n < 40) begin
         rd(GCS_OFFSET, d);
         n++;
      end
      cmp(n < 40, 1'h1);
      cmp(d, expWord());
   endtask : poll

   initial begin
      #200us;
      nErrors++;
      finish_test();
   end

   initial begin
      rstn = 1'h0;
      {regWrite, regRead, slow, writeCountZero, addonMasterEnable} = 5'h00;
      regAddr = 8'h00;
      regWdata = 32'h00000000;
      bistCode = 4'h0;
      expEn = 1'h0;
      expPort = 8'h00;
      void'($urandom(54657));
      repeat (3) @(posedge sys_clk);
      rstn <= 1'h1;
      #1 cmp({nvWriteN, nvReadN, nvDataOe, xferCountEnable}, 4'hC);
      cmp(nvAddr, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         bistCode <= 4'($urandom);
         {writeCountZero, addonMasterEnable} <= 2'($urandom);
         regWdata <= $urandom;
         // Bit 31 low: inactive, fields still act
         @(posedge sys_clk);
         wr(GCS_OFFSET, {1'h0, regWdata[30:0]} | 32'h01000F00);
         expEn = regWdata[28];
         #1 cmp({xferCountEnable, mailboxFlagReset, outFifoStatusReset,
            inFifoStatusReset}, regWdata[28:25]);
         @(posedge sys_clk);
         #1 cmp({mailboxFlagReset, outFifoStatusReset,
            inFifoStatusReset}, 3'h0);
         rd(GCS_OFFSET, d);
         cmp(d, expWord());
      end
      wr(GCS_OFFSET + 8'h04, 32'hFFFFFFFF);
      rd(GCS_OFFSET + 8'h04, d);
      cmp(d, 32'h00000000);
      cmp(xferCountEnable, expEn);
      // this bench is the only memory master
      for (int i = 0; i < 4; i++) begin
         a = 16'($urandom);
         b = 8'($urandom);
         slow = i[0];
         step(NV_LOAD_LO, a[7:0]);
         step(NV_LOAD_HI, a[15:8]);
         #1 cmp(nvAddr, a);
         step(NV_WRITE, b);
         expQ.push_back(b);
         step(NV_LOAD_LO, ~a[7:0]);
         #1 cmp(nvAddr, a);
         poll();
         step(NV_READ, 8'h00);
         expPort = expQ.pop_front();
         poll();
      end
      finish_test();
   end
endmodule : tb_top
